// file: dv/dual_resistor_serial_cmd_port_props.sv
// Timing checks on the serial command port, seen from its ports only.
// Assumes the core clock domain; link pins are sampled as plain levels.
module dual_resistor_serial_cmd_port_props #(
    parameter int unsigned STORE_CYCLES = 20
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic linkClk,
    input wire logic csN,
    input wire logic sdi,
    input wire logic sdoOut,
    input wire logic sdoOeN,
    input wire logic wpN,
    input wire logic presetStrobeN,
    input wire logic rdyOut,
    input wire logic rdyOeN,
    input wire logic [9:0] wiperRegOne,
    input wire logic [9:0] wiperRegTwo
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    logic [7:0] sinceEvt;
    logic [7:0] rdyLow;

    // Cycles since select rose or the strobe moved
    always_ff @(posedge core_clk) begin
        if (sys_rst || $rose(csN) || $changed(presetStrobeN)) begin
            sinceEvt <= 8'h00;
        end else if (sinceEvt != 8'hFF) begin
            sinceEvt <= sinceEvt + 8'h01;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst || rdyOeN) begin
            rdyLow <= 8'h00;
        end else if (rdyLow != 8'hFF) begin
            rdyLow <= rdyLow + 8'h01;
        end
    end

    AST_SDO_RELEASED:
        assert property (csN |-> sdoOeN) else $error("serial output driven while deselected");
    AST_SDO_LOW_ONLY:
        assert property (sdoOut == 1'b0) else $error("serial output data not low");
    AST_RDY_LOW_ONLY:
        assert property (rdyOut == 1'b0) else $error("ready output data not low");
    AST_RDY_HOLD:
        assert property ($fell(rdyOeN) |=> !rdyOeN [*8]) else $error("ready pulse too short");
    AST_RDY_LEN:
        assert property ($rose(rdyOeN) |-> rdyLow == 8'h32) else $error("ready pulse length wrong");
    AST_PRESET_MID:
        assert property (!presetStrobeN [*8] |-> wiperRegOne == 10'h200 && wiperRegTwo == 10'h200)
            else $error("preset did not force midscale");
    AST_EXEC_ON_RISE:
        assert property (($changed(wiperRegOne) || $changed(wiperRegTwo)) |-> sinceEvt inside {[1:12]})
            else $error("wiper changed away from select rise");
    AST_RESET_LOAD:
        assert property ($fell(sys_rst) |-> ##2 (wiperRegOne == 10'h200 && wiperRegTwo == 10'h200))
            else $error("wipers not loaded from stored words");
endmodule : dual_resistor_serial_cmd_port_props

bind dual_resistor_serial_cmd_port dual_resistor_serial_cmd_port_props #(.STORE_CYCLES(STORE_CYCLES)) i_props (
    .core_clk(core_clk), .sys_rst(sys_rst), .linkClk(linkClk), .csN(csN), .sdi(sdi),
    .sdoOut(sdoOut), .sdoOeN(sdoOeN), .wpN(wpN), .presetStrobeN(presetStrobeN), .rdyOut(rdyOut),
    .rdyOeN(rdyOeN), .wiperRegOne(wiperRegOne), .wiperRegTwo(wiperRegTwo)
);

// file: dv/dual_resistor_serial_cmd_port_tb.sv
// Self-checking bench for the serial command port, one task per scenario.
// Assumes the host model on the link; store time shortened to keep the run brief.
module dual_resistor_serial_cmd_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic wpN = 1'b1;
    logic presetStrobeN = 1'b1;
    wire logic linkClk;
    wire logic csN;
    wire logic sdi;
    logic sdoOut;
    logic sdoOeN;
    logic rdyOut;
    logic rdyOeN;
    logic [9:0] wiperRegOne;
    logic [9:0] wiperRegTwo;
    logic [47:0] rx;
    int badCount = 0;
    int checkCount = 0;

    always #10 core_clk = ~core_clk;

    dual_resistor_serial_cmd_port #(.STORE_CYCLES(60)) i_dual_resistor_serial_cmd_port (
        .core_clk(core_clk), .sys_rst(sys_rst), .linkClk(linkClk), .csN(csN), .sdi(sdi),
        .sdoOut(sdoOut), .sdoOeN(sdoOeN), .wpN(wpN), .presetStrobeN(presetStrobeN), .rdyOut(rdyOut),
        .rdyOeN(rdyOeN), .wiperRegOne(wiperRegOne), .wiperRegTwo(wiperRegTwo)
    );

    spi_host_model i_spi_host_model (.linkClk(linkClk), .csN(csN), .sdi(sdi), .sdoOeN(sdoOeN));

    task automatic giveVerdict();
        if (badCount == 0 && checkCount > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : giveVerdict

    task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        checkCount++;
        if (g !== e) begin
            badCount++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wip(input logic [9:0] e1, input logic [9:0] e2);
        chk("wiperRegOne", {14'h0000, e1}, {14'h0000, wiperRegOne});
        chk("wiperRegTwo", {14'h0000, e2}, {14'h0000, wiperRegTwo});
    endtask : wip

    // Frame, then time for the core to act on the select rise
    task automatic run(input int n, input logic [47:0] tx, input int hp = 3, input logic cpol = 1'b0);
        i_spi_host_model.xfer(n, tx, hp, cpol, rx);
        repeat (8) @(negedge core_clk);
    endtask : run

    task automatic waitRdy();
        int n;
        n = 0;
        while (rdyOeN !== 1'b0 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        while (rdyOeN !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 400) begin
            badCount++;
            $display("unexpected rdyOeN expected pulse seen none");
            giveVerdict();
        end
    endtask : waitRdy

    task automatic scnWrite();
        chk("sdoOeN", 24'h000001, {23'h000000, sdoOeN});
        wip(10'h200, 10'h200);
        run(24, 48'hB00100);
        wip(10'h100, 10'h200);
        run(24, 48'hB3FD55);
        wip(10'h100, 10'h155);
        run(24, 48'hA00000);
        run(24, 48'h000000);
        chk("readback", 24'hA00100, rx[23:0]);
    endtask : scnWrite

    task automatic scnChainCount();
        run(48, {24'hB00111, 24'hB10222}, 12);
        wip(10'h100, 10'h222);
        run(24, 48'h000000);
        chk("chained", 24'hB10222, rx[23:0]);
        run(23, 48'h580199);
        run(25, 48'h0B00333);
        wip(10'h100, 10'h222);
        run(20, 48'h0B0012);
        run(4, 48'h000003);
        wip(10'h123, 10'h222);
        run(24, 48'hE00000);
        run(0, 48'h000000);
        wip(10'h125, 10'h222);
    endtask : scnChainCount

    task automatic scnProtect();
        @(negedge core_clk) wpN = 1'b0;
        repeat (4) @(negedge core_clk);
        run(24, 48'hB00000);
        run(24, 48'hE10000);
        wip(10'h125, 10'h222);
        run(24, 48'h100000);
        run(24, 48'h800000);
        wip(10'h200, 10'h200);
        wpN = 1'b1;
        repeat (4) @(negedge core_clk);
    endtask : scnProtect

    task automatic scnStore();
        run(24, 48'hB00155);
        run(24, 48'h200000);
        run(24, 48'hB00077);
        waitRdy();
        wip(10'h155, 10'h200);
        run(24, 48'hB00000);
        run(24, 48'h100000);
        wip(10'h155, 10'h200);
        run(24, 48'h3E1234);
        waitRdy();
        run(24, 48'h9E0000);
        run(24, 48'h000000);
        chk("userWord", 24'h9E1234, rx[23:0]);
        run(24, 48'h3FABCD);
        run(24, 48'h9F0000);
        run(24, 48'h000000);
        chk("factoryWord", 24'h9F0200, rx[23:0]);
    endtask : scnStore

    task automatic scnPresetMode();
        presetStrobeN = 1'b0;
        repeat (10) @(negedge core_clk);
        wip(10'h200, 10'h200);
        presetStrobeN = 1'b1;
        repeat (10) @(negedge core_clk);
        wip(10'h155, 10'h200);
        run(24, 48'hB10321, 3, 1'b1);
        wip(10'h155, 10'h321);
    endtask : scnPresetMode

    initial begin
        i_spi_host_model.tick(4);
        repeat (8) @(negedge core_clk);
        sys_rst = 1'b0;
        // Link side leaves reset only on its own edges
        i_spi_host_model.tick(4);
        repeat (8) @(negedge core_clk);
        scnWrite();
        scnChainCount();
        scnProtect();
        scnStore();
        scnPresetMode();
        giveVerdict();
    end
endmodule : dual_resistor_serial_cmd_port_tb

// file: dv/spi_host_model.sv
// Host side of the serial link: a mode 0 or mode 3 master that shifts a given number of bits.
// Assumes a pull-up on the open-drain serial output, so a released line reads high.
module spi_host_model (
    // Link
    output logic linkClk,
    output logic csN,
    output logic sdi,
    // Open-drain return
    input wire logic sdoOeN
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        linkClk = 1'b0;
        csN = 1'b1;
        sdi = 1'b0;
    end

    // Select held high; settles the link copy of reset
    task automatic tick(input int n);
        repeat (n) begin
            #3 linkClk = 1'b1;
            #3 linkClk = 1'b0;
        end
    endtask : tick

    task automatic xfer(input int n, input logic [47:0] tx, input int hp, input logic cpol,
                        output logic [47:0] rx);
        rx = 48'h0;
        linkClk = cpol;
        #5 csN = 1'b0;
        #40;
        for (int i = n - 1; i >= 0; i--) begin
            linkClk = 1'b0;
            sdi = tx[i];
            #(hp - 1);
            rx = {rx[46:0], sdoOeN};
            #1 linkClk = 1'b1;
            #hp;
        end
        linkClk = cpol;
        #5 csN = 1'b1;
        // Released line must not look like the last bit
        sdi = ~sdi;
        #200;
    endtask : xfer
endmodule : spi_host_model

// file: hdl/dual_resistor_serial_cmd_port.sv
// Serial command front end of a dual-channel nonvolatile digital resistor.
// Assumes an SPI master in mode 0 or 3, link clock still while chip select is high,
// and external pull-ups on the open-drain serial and ready outputs.
// Functional notes
// - Write-protect low blocks wiper changes except restore, refresh and preset.
// - Serial output released whenever chip select is high.
// - Frames are 24 bits, most significant bit first.
// - Top four bits are command, next four bits address.
// - Wiper operations select channel by lowest address bit only.
// - Storage words at addresses 2 to 14; address 15 reserved.
// - Low ten data bits feed wipers; sixteen bits feed storage words.
// - Execute only when bit count accumulated over windows is a multiple of 24.
// - Count not multiple of four at chip select rise resets counter.
// - Bare chip select pulse repeats previous command, except after power-up.
// - Sample on rising link clock; works in modes 0,0 and 1,1.
// - Readback commands return wiper or storage word in next frame.
// - Other commands pass the shifted frame onward for chaining.
// - After reset, wipers load from stored values.
// - Commands execute only when chip select returns high.
// - Outside readback, output shifts last 24 bits received.
// - During store, windows are not executed; ready pulses low at completion.
// - Preset low forces midscale; stored value loads on its rise.
`include "resistor_port_map.svh"

module dual_resistor_serial_cmd_port #(
    parameter int unsigned STORE_CYCLES = `STORE_CYCLES
) (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Serial link
    input wire logic linkClk,
    input wire logic csN,
    input wire logic sdi,
    output logic sdoOut,
    output logic sdoOeN,
    // Control pins
    input wire logic wpN,
    input wire logic presetStrobeN,
    output logic rdyOut,
    output logic rdyOeN,
    // Wiper values
    output logic [9:0] wiperRegOne,
    output logic [9:0] wiperRegTwo
);
    localparam logic [19:0] RDY_CYCLES = 20'(`RDY_PULSE_CYCLES);
    localparam logic [7:0] FRAME_LEN = 8'(`FRAME_BITS);

    // Link domain state
    logic [23:0] shiftReg;
    logic [7:0] linkCount;
    logic linkRst1;
    logic linkRst2;

    // Core domain state
    logic csLevel;
    logic csPrev;
    logic lockWin;
    logic wpLevel;
    logic presetLevel;
    logic presetPrev;
    logic [7:0] countBase;
    logic [7:0] pending;
    logic [23:0] lastFrame;
    logic lastValid;
    logic powerOnLoad;
    logic [15:0] nvStore [`NV_WORDS];
    logic [9:0] wiper [2];
    logic readbackActive;
    logic [23:0] readbackWord;
    logic busy;
    logic [19:0] timer;
    resistor_port_pkg::store_state_t storeState;
    logic [3:0] storeAddr;
    logic [15:0] storeData;

    // Frame decision
    logic csEdge;
    logic csRise;
    logic [7:0] delta;
    logic [7:0] total;
    logic execNow;
    logic [23:0] execFrame;
    resistor_port_pkg::cmd_t execCmd;
    logic [3:0] execAddr;
    logic execSel;

    function automatic logic [9:0] stepWiper(input logic [3:0] cmd, input logic [9:0] w);
        logic [9:0] r;
        r = w;
        unique case (cmd)
            4'h4, 4'h5: r = w >> 1;
            4'h6, 4'h7: r = (w == 10'h000) ? w : w - 10'h001;
            4'hC, 4'hD: r = w[`WIPER_MSB] ? `WIPER_FULL : (w << 1);
            4'hE, 4'hF: r = (w == `WIPER_FULL) ? w : w + 10'h001;
            default: r = w;
        endcase
        return r;
    endfunction : stepWiper

    function automatic logic isStep(input logic [3:0] cmd);
        return (cmd >= 4'h4 && cmd <= 4'h7) || cmd >= 4'hC;
    endfunction : isStep

    // Link reset brought onto the link clock
    always_ff @(posedge linkClk) begin
        linkRst1 <= sys_rst;
        linkRst2 <= linkRst1;
    end

    // MSB-first capture
    // Store lock is judged in the core: a copy of busy here would lag a whole window
    always_ff @(posedge linkClk) begin
        if (linkRst2) begin
            shiftReg <= 24'h000000;
            linkCount <= 8'h00;
        end else if (!csN) begin
            shiftReg <= {shiftReg[22:0], sdi};
            linkCount <= linkCount + 8'h01;
        end
    end

    // Bit position within the current window; countBase is static while csN is low
    logic [7:0] linkIdx;
    logic readbackBit;
    assign linkIdx = linkCount - countBase;
    assign readbackBit = readbackWord[5'(`FRAME_MSB - linkIdx[4:0])];

    // readback or chained frame
    // Chip select must gate the pin with no clock edge, so this path is combinational.
    assign sdoOut = 1'b0;
    assign sdoOeN = csN | ((readbackActive && linkIdx < FRAME_LEN) ? readbackBit : shiftReg[`FRAME_MSB]);

    pin_sync csSync (
        .clk(core_clk),
        .rst(sys_rst),
        .resetLevel(1'b1),
        .pin(csN),
        .level(csLevel)
    );

    pin_sync wpSync (
        .clk(core_clk),
        .rst(sys_rst),
        .resetLevel(1'b1),
        .pin(wpN),
        .level(wpLevel)
    );

    pin_sync presetSync (
        .clk(core_clk),
        .rst(sys_rst),
        .resetLevel(1'b1),
        .pin(presetStrobeN),
        .level(presetLevel)
    );

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            csPrev <= 1'b1;
            presetPrev <= 1'b1;
        end else begin
            csPrev <= csLevel;
            presetPrev <= presetLevel;
        end
    end

    // Window start seen during a store locks the whole window
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lockWin <= 1'b0;
        end else if (csPrev && !csLevel) begin
            lockWin <= busy;
        end
    end

    assign csEdge = csLevel && !csPrev;
    // windows begun during a store are dropped
    assign csRise = csEdge && !busy && !lockWin;
    // Link clock is still here, so the counter and shift register are stable words
    assign delta = linkCount - countBase;
    assign total = pending + delta;

    always_comb begin
        execNow = 1'b0;
        execFrame = shiftReg;
        if (csRise) begin
            if (delta == 8'h00) begin
                execNow = lastValid;
                execFrame = lastFrame;
            end else if (total % FRAME_LEN == 8'h00) begin
                execNow = 1'b1;
            end
        end
    end

    assign execCmd = resistor_port_pkg::cmd_t'(execFrame[`CMD_MSB:`CMD_LSB]);
    assign execAddr = execFrame[`ADDR_MSB:`ADDR_LSB];
    assign execSel = execAddr[0];

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            countBase <= 8'h00;
            pending <= 8'h00;
        end else if (csEdge) begin
            // Bits of a dropped window never count
            countBase <= linkCount;
            if (csRise) begin
                if (total % `NIBBLE_BITS != 8'h00 || total % FRAME_LEN == 8'h00) begin
                    pending <= 8'h00;
                end else begin
                    pending <= total;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            lastFrame <= 24'h000000;
            lastValid <= 1'b0;
        end else if (execNow) begin
            lastFrame <= execFrame;
            lastValid <= 1'b1;
        end
    end

    // readback word for the next window
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            readbackActive <= 1'b0;
            readbackWord <= 24'h000000;
        end else if (csRise) begin
            readbackActive <= 1'b0;
            if (execNow && execCmd == resistor_port_pkg::CMD_READ_NV) begin
                readbackActive <= 1'b1;
                readbackWord <= {execFrame[23:16], nvStore[execAddr]};
            end else if (execNow && execCmd == resistor_port_pkg::CMD_READ_WIPER) begin
                readbackActive <= 1'b1;
                readbackWord <= {execFrame[23:16], 6'h00, wiper[execSel]};
            end
        end
    end

    // Store sequencer
    // timed store and ready pulse
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            storeState <= resistor_port_pkg::ST_IDLE;
            timer <= 20'h00000;
            busy <= 1'b0;
            rdyOeN <= 1'b1;
            storeAddr <= 4'h0;
            storeData <= 16'h0000;
        end else begin
            unique case (storeState)
                resistor_port_pkg::ST_IDLE: begin
                    if (execNow && execCmd == resistor_port_pkg::CMD_STORE_WIPER) begin
                        storeState <= resistor_port_pkg::ST_STORE;
                        busy <= 1'b1;
                        timer <= 20'(STORE_CYCLES - 1);
                        storeAddr <= {3'b000, execSel};
                        storeData <= {6'h00, wiper[execSel]};
                    end else if (execNow && execCmd == resistor_port_pkg::CMD_STORE_WORD
                                 && execAddr != `NV_FACTORY_ADDR) begin
                        storeState <= resistor_port_pkg::ST_STORE;
                        busy <= 1'b1;
                        timer <= 20'(STORE_CYCLES - 1);
                        storeAddr <= execAddr;
                        storeData <= execFrame[`DATA_MSB:0];
                    end
                end
                resistor_port_pkg::ST_STORE: begin
                    if (timer == 20'h00000) begin
                        storeState <= resistor_port_pkg::ST_READY;
                        busy <= 1'b0;
                        rdyOeN <= 1'b0;
                        timer <= RDY_CYCLES - 20'h00001;
                    end else begin
                        timer <= timer - 20'h00001;
                    end
                end
                resistor_port_pkg::ST_READY: begin
                    if (timer == 20'h00000) begin
                        storeState <= resistor_port_pkg::ST_IDLE;
                        rdyOeN <= 1'b1;
                    end else begin
                        timer <= timer - 20'h00001;
                    end
                end
            endcase
        end
    end

    assign rdyOut = 1'b0;

    // Storage words hold factory midscale after reset
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            for (int i = 0; i < `NV_WORDS; i++) begin
                nvStore[i] <= `NV_RESET;
            end
        end else if (storeState == resistor_port_pkg::ST_STORE && timer == 20'h00000) begin
            nvStore[storeAddr] <= storeData;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            powerOnLoad <= 1'b1;
        end else begin
            powerOnLoad <= 1'b0;
        end
    end

    // Wiper registers
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wiper[0] <= `WIPER_MID;
            wiper[1] <= `WIPER_MID;
        end else if (!presetLevel) begin
            wiper[0] <= `WIPER_MID;
            wiper[1] <= `WIPER_MID;
        end else if (powerOnLoad || (presetLevel && !presetPrev)) begin
            wiper[0] <= nvStore[0][`WIPER_MSB:0];
            wiper[1] <= nvStore[1][`WIPER_MSB:0];
        end else if (execNow) begin
            unique case (execCmd)
                resistor_port_pkg::CMD_RESTORE: begin
                    wiper[execSel] <= nvStore[{3'b000, execSel}][`WIPER_MSB:0];
                end
                resistor_port_pkg::CMD_REFRESH_ALL: begin
                    wiper[0] <= nvStore[0][`WIPER_MSB:0];
                    wiper[1] <= nvStore[1][`WIPER_MSB:0];
                end
                resistor_port_pkg::CMD_WRITE_WIPER: begin
                    if (wpLevel) begin
                        wiper[execSel] <= execFrame[`WIPER_MSB:0];
                    end
                end
                default: begin
                    if (wpLevel && isStep(execCmd)) begin
                        if (execCmd[0]) begin
                            wiper[0] <= stepWiper(execCmd, wiper[0]);
                            wiper[1] <= stepWiper(execCmd, wiper[1]);
                        end else begin
                            wiper[execSel] <= stepWiper(execCmd, wiper[execSel]);
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        wiperRegOne <= wiper[0];
        wiperRegTwo <= wiper[1];
    end

endmodule : dual_resistor_serial_cmd_port

// file: hdl/pin_sync.sv
// Three-stage synchroniser for a pin entering the core clock domain.
// The output follows only once the second and third stages agree.
module pin_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic resetLevel,
    // Pin and result
    input wire logic pin,
    output logic level
);
    logic stage1;
    logic stage2;
    logic stage3;

    always_ff @(posedge clk) begin
        stage1 <= pin;
        stage2 <= stage1;
        stage3 <= stage2;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            level <= resetLevel;
        end else if (stage2 == stage3) begin
            level <= stage3;
        end
    end

endmodule : pin_sync

// file: hdl/resistor_port_map.svh
// Offsets, field positions, reset values and timing counts of the serial command port.
// Included by the dual_resistor_serial_cmd_port module; definitions only.
`ifndef RESISTOR_PORT_MAP_SVH
`define RESISTOR_PORT_MAP_SVH

`define FRAME_BITS 24
`define FRAME_MSB 23
`define CMD_MSB 23
`define CMD_LSB 20
`define ADDR_MSB 19
`define ADDR_LSB 16
`define DATA_MSB 15
`define WIPER_MSB 9
`define NV_WORDS 16
`define NV_FACTORY_ADDR 4'hF
`define WIPER_MID 10'h200
`define WIPER_FULL 10'h3FF
`define NV_RESET 16'h0200
`define NIBBLE_BITS 8'h04
`define CORE_CLK_HZ 50000000
`define STORE_TIME_MS 15
`define STORE_CYCLES ((`STORE_TIME_MS * `CORE_CLK_HZ) / 1000)
`define RDY_PULSE_NS 1000
`define RDY_PULSE_CYCLES ((`RDY_PULSE_NS * (`CORE_CLK_HZ / 1000000) + 999) / 1000)

`endif

// file: hdl/resistor_port_pkg.sv
// Types shared by the serial command port modules.
// Assumes resistor_port_map.svh holds all numeric constants.
package resistor_port_pkg;

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_RESTORE = 4'h1,
        CMD_STORE_WIPER = 4'h2,
        CMD_STORE_WORD = 4'h3,
        CMD_HALVE = 4'h4,
        CMD_HALVE_ALL = 4'h5,
        CMD_DEC = 4'h6,
        CMD_DEC_ALL = 4'h7,
        CMD_REFRESH_ALL = 4'h8,
        CMD_READ_NV = 4'h9,
        CMD_READ_WIPER = 4'hA,
        CMD_WRITE_WIPER = 4'hB,
        CMD_DOUBLE = 4'hC,
        CMD_DOUBLE_ALL = 4'hD,
        CMD_INC = 4'hE,
        CMD_INC_ALL = 4'hF
    } cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STORE,
        ST_READY
    } store_state_t;

endpackage : resistor_port_pkg
